// ==== include/setup_regs_pkg.sv ====
// register map, field positions, reset values and timing for the analog setup block
`default_nettype none
package setup_regs_pkg;
    // register indices; byte address is four times the index
    localparam logic [5:0] ANALOG_FRONT_SETUP_IDX = 6'h03;
    localparam logic [5:0] CONVERSION_SETUP_IDX = 6'h04;
    localparam logic [5:0] REFERENCE_SETUP_IDX = 6'h20;
    localparam logic [5:0] CONVERSION_CONTROL_IDX = 6'h21;
    localparam logic [5:0] CONVERSION_STATUS_IDX = 6'h22;
    localparam logic [7:0] ANALOG_FRONT_SETUP_ADDR = {ANALOG_FRONT_SETUP_IDX, 2'b00};
    localparam logic [7:0] CONVERSION_SETUP_ADDR = {CONVERSION_SETUP_IDX, 2'b00};
    localparam logic [7:0] REFERENCE_SETUP_ADDR = {REFERENCE_SETUP_IDX, 2'b00};
    localparam logic [7:0] CONVERSION_CONTROL_ADDR = {CONVERSION_CONTROL_IDX, 2'b00};
    localparam logic [7:0] CONVERSION_STATUS_ADDR = {CONVERSION_STATUS_IDX, 2'b00};
    // reset values
    localparam logic [7:0] ANALOG_FRONT_SETUP_RESET = 8'h8b;
    localparam logic [7:0] CONVERSION_SETUP_RESET = 8'h00;
    localparam logic [7:0] REFERENCE_SETUP_RESET = 8'h00;
    // analog_front_setup fields
    localparam int BIAS_MSB = 7;
    localparam int BIAS_LSB = 6;
    localparam int GAIN_MSB = 5;
    localparam int GAIN_LSB = 3;
    localparam int MUX_AZ_BIT = 2;
    localparam int REF_CHOP_BIT = 1;
    localparam int RESERVED_BIT = 0;
    // conversion_setup fields
    localparam int CONV_MODE_MSB = 7;
    localparam int CONV_MODE_LSB = 6;
    localparam logic [1:0] CONV_MODE_CONTINUOUS = 2'h3;
    // reference_setup, conversion_control and conversion_status fields
    localparam int REF_INTERNAL_BIT = 0;
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_STOP_BIT = 1;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_SERIES_BIT = 1;
    // bias current codes
    localparam logic [1:0] BIAS_X2 = 2'h3;
    localparam logic [1:0] BIAS_X1 = 2'h2;
    localparam logic [1:0] BIAS_X066 = 2'h1;
    localparam logic [1:0] BIAS_X05 = 2'h0;
    // gain codes
    localparam logic [2:0] GAIN_THIRD = 3'h0;
    localparam logic [2:0] GAIN_X1 = 3'h1;
    localparam logic [2:0] GAIN_X16 = 3'h5;
    localparam logic [2:0] GAIN_X32 = 3'h6;
    localparam logic [2:0] GAIN_X64 = 3'h7;
    localparam logic [1:0] DIG_SHIFT_NONE = 2'h0;
    localparam logic [1:0] DIG_SHIFT_X2 = 2'h1;
    localparam logic [1:0] DIG_SHIFT_X4 = 2'h2;
    // timing: base conversion time in ns at a 50 ns clock
    localparam int CLK_PERIOD_NS = 50;
    localparam int BASE_CONV_NS = 3200;
    localparam int BASE_CONV_CYCLES = (BASE_CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int AZ_FACTOR = 2;
endpackage : setup_regs_pkg
`default_nettype wire

// ==== rtl/analog_setup_regs.sv ====
// apb register bank for the analog front setup with conversion sequencing
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module analog_setup_regs
    import setup_regs_pkg::*;
#(
    parameter int BASE_CYCLES = BASE_CONV_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [1:0] bias_current_sel,
    output logic [2:0] analog_gain_sel,
    output logic [1:0] digital_gain_shift,
    output logic input_mux_autozero_active,
    output logic reference_chop_active,
    output logic conv_busy,
    output logic conv_done,
    output logic conv_start_pulse
);
    logic [7:0] analog_front_setup_reg;
    logic [7:0] conversion_setup_reg;
    logic [7:0] reference_setup_reg;
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pslverr_reg;
    logic [1:0] bias_reg;
    logic [2:0] gain_reg;
    logic [1:0] shift_reg;
    logic az_reg, chop_reg;
    logic busy_w, start_w, done_w, series_w;

    // bus decode
    wire setup_phase = psel && !penable;
    wire access_done = psel && penable && pready_reg;
    wire wr = access_done && pwrite;
    wire hit_front = (paddr == ANALOG_FRONT_SETUP_ADDR);
    wire hit_conv = (paddr == CONVERSION_SETUP_ADDR);
    wire hit_ref = (paddr == REFERENCE_SETUP_ADDR);
    wire hit_ctrl = (paddr == CONVERSION_CONTROL_ADDR);
    wire hit_stat = (paddr == CONVERSION_STATUS_ADDR);
    wire mapped = hit_front || hit_conv || hit_ref || hit_ctrl || hit_stat;
    wire sw_start = wr && hit_ctrl && pwdata[CTRL_START_BIT];
    wire sw_stop = wr && hit_ctrl && pwdata[CTRL_STOP_BIT];
    wire continuous = (conversion_setup_reg[CONV_MODE_MSB:CONV_MODE_LSB] == CONV_MODE_CONTINUOUS);

    // field decode of the stored value
    wire [1:0] bias_field = analog_front_setup_reg[BIAS_MSB:BIAS_LSB];
    wire [2:0] gain_field = analog_front_setup_reg[GAIN_MSB:GAIN_LSB];
    wire [2:0] analog_gain_w = (gain_field >= GAIN_X32) ? GAIN_X16 : gain_field;
    wire [1:0] dig_shift_w = (gain_field == GAIN_X64) ? DIG_SHIFT_X4 :
        (gain_field == GAIN_X32) ? DIG_SHIFT_X2 : DIG_SHIFT_NONE;
    wire mux_az_w = analog_front_setup_reg[MUX_AZ_BIT];
    wire chop_w = analog_front_setup_reg[REF_CHOP_BIT] && reference_setup_reg[REF_INTERNAL_BIT];

    always_comb begin
        prdata_next = 32'h0000_0000;
        if (hit_front) begin
            prdata_next[7:0] = analog_front_setup_reg;
        end else if (hit_conv) begin
            prdata_next[7:0] = conversion_setup_reg;
        end else if (hit_ref) begin
            prdata_next[7:0] = reference_setup_reg;
        end else if (hit_stat) begin
            prdata_next[STAT_BUSY_BIT] = busy_w;
            prdata_next[STAT_SERIES_BIT] = series_w;
        end
    end

    // one wait-free access cycle: ready is raised from the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
        end else begin
            pready_reg <= setup_phase;
        end
    end

    // error rides with ready so a master never sees it alone
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr_reg <= 1'b0;
        end else begin
            pslverr_reg <= setup_phase && !mapped;
        end
    end

    // read data captured at setup, held until the next read
    wire rd_capture = setup_phase && !pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
        end else if (rd_capture) begin
            prdata_reg <= prdata_next;
        end
    end

    // per-register write strobes; unmapped writes fall through
    wire wr_front = wr && hit_front;
    wire wr_conv = wr && hit_conv;
    wire wr_ref = wr && hit_ref;

    // not forced to one: software owns that bit
    // reserved kept as written
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_front_setup_reg <= ANALOG_FRONT_SETUP_RESET;
        end else if (wr_front) begin
            analog_front_setup_reg <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conversion_setup_reg <= CONVERSION_SETUP_RESET;
        end else if (wr_conv) begin
            conversion_setup_reg <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reference_setup_reg <= REFERENCE_SETUP_RESET;
        end else if (wr_ref) begin
            reference_setup_reg <= pwdata[7:0];
        end
    end

    conversion_timer #(
        .BASE_CYCLES(BASE_CYCLES)
    ) u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .start(sw_start),
        .stop(sw_stop),
        .continuous(continuous),
        .autozero(mux_az_w),
        .busy(busy_w),
        .conv_start(start_w),
        .conv_done(done_w),
        .oneshot_series(series_w)
    );

    // settings other than reference chop move only at a start pulse, so a write mid-conversion waits; chop follows every cycle
    // latched at start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bias_reg <= BIAS_X1;
        end else if (start_w) begin
            bias_reg <= bias_field;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gain_reg <= GAIN_X1;
        end else if (start_w) begin
            gain_reg <= analog_gain_w;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_reg <= DIG_SHIFT_NONE;
        end else if (start_w) begin
            shift_reg <= dig_shift_w;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            az_reg <= 1'b0;
        end else if (start_w) begin
            az_reg <= mux_az_w;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chop_reg <= 1'b0;
        end else begin
            chop_reg <= chop_w;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign bias_current_sel = bias_reg;
    assign analog_gain_sel = gain_reg;
    assign digital_gain_shift = shift_reg;
    assign input_mux_autozero_active = az_reg;
    assign reference_chop_active = chop_reg;
    assign conv_busy = busy_w;
    assign conv_done = done_w;
    assign conv_start_pulse = start_w;
endmodule : analog_setup_regs
`default_nettype wire

// ==== rtl/conversion_timer.sv ====
// conversion timing sequencer: one-shot, continuous and auto-zero series
`timescale 1ns/100ps
`default_nettype none
module conversion_timer
    import setup_regs_pkg::*;
#(
    parameter int BASE_CYCLES = BASE_CONV_CYCLES,
    parameter int CW = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic stop,
    input wire logic continuous,
    input wire logic autozero,
    output logic busy,
    output logic conv_start,
    output logic conv_done,
    output logic oneshot_series
);
    typedef enum logic {IDLE, CONVERT} timer_state_t;
    timer_state_t state_reg, state_next;
    logic [CW-1:0] count_reg, count_next;
    logic az_reg, cont_reg;
    logic [CW-1:0] length;
    logic last;
    logic cont_go;
    logic series_restart;

    assign length = az_reg ? CW'(BASE_CYCLES * AZ_FACTOR) : CW'(BASE_CYCLES);
    assign last = (count_reg == length - CW'(1));
    assign cont_go = cont_reg && !stop;
    assign series_restart = (state_reg == CONVERT) && last && cont_go && az_reg;

    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        unique case (state_reg)
            IDLE: begin
                count_next = '0;
                if (start && !stop) begin
                    state_next = CONVERT;
                end
            end
            CONVERT: begin
                count_next = count_reg + CW'(1);
                if (stop) begin
                    state_next = IDLE;
                    count_next = '0;
                end else if (last) begin
                    count_next = '0;
                    state_next = cont_go ? CONVERT : IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= IDLE;
            count_reg <= '0;
            az_reg <= 1'b0;
            cont_reg <= 1'b0;
            conv_start <= 1'b0;
            conv_done <= 1'b0;
            oneshot_series <= 1'b0;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
            conv_done <= (state_reg == CONVERT) && last && !stop;
            conv_start <= (state_reg == IDLE && start && !stop) || series_restart;
            // a refused start (stop in the same write) latches nothing
            if (state_reg == IDLE && start && !stop) begin
                az_reg <= autozero;
                cont_reg <= continuous;
                oneshot_series <= continuous && autozero;
            end else if (series_restart) begin
                // relatched like the other settings, so a cleared bit ends the series
                az_reg <= autozero;
                oneshot_series <= autozero;
            end else if (state_next == IDLE) begin
                oneshot_series <= 1'b0;
            end
        end
    end

    assign busy = (state_reg == CONVERT);
endmodule : conversion_timer
`default_nettype wire

// ==== test/analog_setup_regs_assertions.sv ====
// port-level checker for the analog setup register bank
`timescale 1ns/100ps
`default_nettype none
module analog_setup_regs_assertions
    import setup_regs_pkg::*;
#(
    parameter int BASE_CYCLES = BASE_CONV_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [1:0] bias_current_sel,
    input wire logic [2:0] analog_gain_sel,
    input wire logic [1:0] digital_gain_shift,
    input wire logic input_mux_autozero_active,
    input wire logic reference_chop_active,
    input wire logic conv_busy,
    input wire logic conv_done,
    input wire logic conv_start_pulse
);
    logic [15:0] busy_reg;
    // busy cycles since the last start pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_reg <= '0;
        end else if (conv_start_pulse) begin
            busy_reg <= 16'h0001;
        end else if (conv_busy) begin
            busy_reg <= busy_reg + 16'h0001;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_one_access;
        pready ##1 !pready;
    endsequence
    a_pready_one_cycle: assert property (s_setup |=> s_one_access)
        else $error("pready not one cycle after setup");
    // error comes only with ready; a refused read returns a zero word, a refused write is not checked
    a_slverr_with_ready: assert property (pslverr |->
        pready && (pwrite || prdata == 32'h0))
        else $error("pslverr without pready or with data");
    a_upper_bits_zero: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("read data above bit 7 not zero");
    a_digital_gain_pair: assert property (digital_gain_shift != DIG_SHIFT_NONE |->
        analog_gain_sel == GAIN_X16 && digital_gain_shift != 2'h3)
        else $error("digital gain without analog sixteen");
    // conversion length, doubled by auto-zero
    a_conv_length: assert property (conv_done && !conv_busy |->
        busy_reg == (input_mux_autozero_active ? 2 * BASE_CYCLES : BASE_CYCLES))
        else $error("conversion length wrong");
    a_series_restart: assert property (conv_done && conv_busy |->
        conv_start_pulse == $past(input_mux_autozero_active))
        else $error("continuous restart mismatch");
    a_latch_at_start: assert property (!conv_start_pulse |=>
        $stable(analog_gain_sel) && $stable(bias_current_sel) &&
        $stable(input_mux_autozero_active) && $stable(digital_gain_shift))
        else $error("settings changed outside start");
    a_done_after_busy: assert property (conv_done |-> $past(conv_busy))
        else $error("done without conversion");
endmodule : analog_setup_regs_assertions
bind analog_setup_regs analog_setup_regs_assertions #(.BASE_CYCLES(BASE_CYCLES)) chk_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bias_current_sel(bias_current_sel), .analog_gain_sel(analog_gain_sel),
    .digital_gain_shift(digital_gain_shift), .conv_busy(conv_busy), .conv_done(conv_done),
    .input_mux_autozero_active(input_mux_autozero_active), .conv_start_pulse(conv_start_pulse),
    .reference_chop_active(reference_chop_active));
`default_nettype wire

// ==== test/analog_setup_regs_tb.sv ====
// self-checking bench for the analog setup register bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(s, e, g) begin tests_run++; if ((g) !== (e)) begin err_total++; \
    $display("Error %s exp %h got %h", s, e, g); end end
module analog_setup_regs_tb;
    import setup_regs_pkg::*;
    localparam int B = 4;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, serr;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rdata;
    logic [1:0] bias, shift;
    logic [2:0] gain;
    logic az, chop, busy, done, start;
    int err_total = 0, tests_run = 0, cyc = 0, n;
    analog_setup_regs #(.BASE_CYCLES(B)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .bias_current_sel(bias), .analog_gain_sel(gain),
        .digital_gain_shift(shift), .input_mux_autozero_active(az), .conv_busy(busy),
        .reference_chop_active(chop), .conv_done(done), .conv_start_pulse(start));
    always #25 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            report_and_stop();
        end
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdata = prdata;
        serr = pslverr;
        psel <= 0; penable <= 0;
    endtask : apb
    // program, start, count cycles up to the done pulse
    task automatic run_conv(input logic [7:0] cfg, input logic [7:0] mode);
        apb(1, ANALOG_FRONT_SETUP_ADDR, {24'h0, cfg});
        apb(1, CONVERSION_SETUP_ADDR, {24'h0, mode});
        apb(1, CONVERSION_CONTROL_ADDR, 32'h1);
        @(posedge pclk);
        `CHK("start", 1'b1, start)
        n = 1;
        do begin @(posedge pclk); n++; end while (done !== 1'b1);
    endtask : run_conv
    task automatic t_reset_map();
        `CHK("bias", BIAS_X1, bias)
        `CHK("gain", GAIN_X1, gain)
        `CHK("az", 1'b0, az)
        `CHK("chop reset", 1'b0, chop)
        apb(0, ANALOG_FRONT_SETUP_ADDR, 0);
        `CHK("afs reset", 32'h8b, rdata)
        apb(0, 8'hfc, 0);
        `CHK("unmapped err", 1'b1, serr)
        `CHK("unmapped data", 32'h0, rdata)
        apb(1, 8'hfc, 32'hff);
        `CHK("unmapped wr err", 1'b1, serr)
    endtask : t_reset_map
    task automatic t_codes();
        logic [7:0] cfg;
        for (int i = 0; i < 8; i++) begin
            // reserved bit kept at one by software
            cfg = {i[1:0], i[2:0], 3'b011};
            run_conv(cfg, 8'h00);
            `CHK("n one-shot", B + 1, n)
            `CHK("bias code", cfg[7:6], bias)
            `CHK("gain code", (i > 5) ? GAIN_X16 : i[2:0], gain)
            `CHK("shift", (i == 6) ? DIG_SHIFT_X2 : (i == 7) ? DIG_SHIFT_X4 : 2'h0, shift)
            apb(0, ANALOG_FRONT_SETUP_ADDR, 0);
            `CHK("readback", {24'h0, cfg}, rdata)
        end
    endtask : t_codes
    task automatic t_autozero();
        run_conv(8'h8f, 8'h00);
        `CHK("n az", 2 * B + 1, n)
        `CHK("az on", 1'b1, az)
        run_conv(8'h8f, 8'hc0);
        `CHK("series restart", 1'b1, start)
        `CHK("series busy", 1'b1, busy)
        apb(0, CONVERSION_STATUS_ADDR, 0);
        `CHK("series status", (32'h1 << STAT_BUSY_BIT) | (32'h1 << STAT_SERIES_BIT), rdata)
        apb(1, CONVERSION_CONTROL_ADDR, 32'h2);
        run_conv(8'h8b, 8'hc0);
        `CHK("true continuous", 1'b0, start)
        apb(1, ANALOG_FRONT_SETUP_ADDR, 32'h9b);
        do @(posedge pclk); while (done !== 1'b1);
        `CHK("gain held", GAIN_X1, gain)
        apb(1, CONVERSION_CONTROL_ADDR, 32'h2);
        @(posedge pclk);
        @(posedge pclk);
        `CHK("stopped", 1'b0, busy)
    endtask : t_autozero
    task automatic t_chop(input logic r, input logic [7:0] cfg, input logic e);
        apb(1, REFERENCE_SETUP_ADDR, {31'h0, r});
        apb(1, ANALOG_FRONT_SETUP_ADDR, {24'h0, cfg});
        @(posedge pclk);
        @(posedge pclk);
        `CHK("chop", e, chop)
    endtask : t_chop
    task automatic report_and_stop();
        if (err_total == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        t_reset_map();
        t_codes();
        t_autozero();
        t_chop(1, 8'h8b, 1);
        t_chop(1, 8'h89, 0);
        t_chop(0, 8'h8b, 0);
        report_and_stop();
    end
endmodule : analog_setup_regs_tb
`default_nettype wire
